/* File: hw/tipio_pkg.sv */
// tipio_pkg: constants for the tick interrupt / parallel io block
// assumes: 250 MHz aclk, AXI4-Lite register access, 32-bit data
package tipio_pkg;

    // ************************************************************
    // clock and tick timing
    // ************************************************************
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned TICK_HZ       = 55;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / TICK_HZ;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_SER_STAT   = 8'h00;
    localparam logic [7:0] OFS_PAR_A      = 8'h20;
    localparam logic [7:0] OFS_PAR_B      = 8'h24;
    localparam logic [7:0] OFS_CFG        = 8'h30;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h38;
    localparam logic [7:0] OFS_VEC_SEL    = 8'h3C;
    localparam logic [7:0] OFS_HS_CTRL    = 8'h40;
    localparam logic [7:0] OFS_HS_STAT    = 8'h44;
    localparam logic [7:0] OFS_IACK      = 8'h48;

    // ************************************************************
    // source bit layout: rx 0..2, tx 3..5, tick 6
    // ************************************************************
    localparam int unsigned NSRC          = 7;
    localparam int unsigned SRC_RX0       = 0;
    localparam int unsigned SRC_TX0       = 3;
    localparam int unsigned SRC_TICK      = 6;

    // cfg register fields
    localparam int unsigned CFG_WIRE_LSB  = 0;
    localparam int unsigned CFG_VI_BIT    = 8;
    localparam int unsigned CFG_GATE_LSB  = 9;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]      RST_PAR_A    = 8'h00;
    localparam logic [7:0]      RST_PAR_B    = 8'h00;
    localparam logic [NSRC-1:0] RST_WIRE     = 7'h00;
    localparam logic [3:0]      RST_VEC_SEL  = 4'h0;
    localparam logic [NSRC-1:0] RST_IRQ_MASK = 7'h00;

    // vector table: nine restart-style opcodes
    localparam int unsigned NVEC          = 9;
    localparam logic [7:0]  VEC_DEFAULT   = 8'hFF;

    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef enum logic [1:0] {
        TIPIO_IDLE = 2'b00,
        TIPIO_RESP = 2'b01
    } tipio_bus_e;

endpackage

/* File: hw/tipio_tick_gen.sv */
// tipio_tick_gen: periodic one-cycle tick enable from a divider
// assumes: single clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tipio_tick_gen #(
    parameter int unsigned PERIOD = 4_545_454
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // tick out
    output logic      tick
);
    localparam int unsigned CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_q;
    wire           wrap = (cnt_q == LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            tick  <= wrap;
        end
    end

    int unsigned gap_q;
    always_ff @(posedge aclk) begin
        if (!aresetn)   gap_q <= 0;
        else if (tick)  gap_q <= 1;
        else if (gap_q != 0) gap_q <= gap_q + 1;
    end

    property p_tick_period;
        @(posedge aclk) disable iff (!aresetn)
        (tick && gap_q != 0) |-> (gap_q == PERIOD);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick spacing wrong");
endmodule
`default_nettype wire

/* File: hw/tipio_sticky.sv */
// tipio_sticky: one set-dominant sticky latch
// assumes: set and clear are one-cycle pulses in aclk domain
`timescale 1ns/1ps
`default_nettype none
module tipio_sticky (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // events
    input  wire logic set,
    input  wire logic clr,
    // state
    output logic      q
);
    always_ff @(posedge aclk) begin
        if (!aresetn)  q <= 1'b0;
        else if (set)  q <= 1'b1;
        else if (clr)  q <= 1'b0;
    end

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        (q && !clr) |=> q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("sticky latch dropped without clear");
endmodule
`default_nettype wire

/* File: hw/tipio_top.sv */
// tipio_top: tick latch, interrupt request, vector and two parallel channels
// assumes: AXI4-Lite master keeps one read and one write outstanding at most
`timescale 1ns/1ps
`default_nettype none

// Function
// - periodic tick at 55 per second
// - tick latch set, held until cleared
// - channel B input read clears tick latch
// - set latch keeps requesting interrupt
// - irq from wired rx, tx, tick sources
// - acknowledge returns one of nine vectors
// - same vector whatever the source
// - optional routing onto vectored interrupt lines
// - two channels, eight in and out
// - output latched until next write
// - input read returns live pins
// - parallel channels raise no interrupt
// - channel A output is serial mask
// - handshake gate, monitor, two controls
// - serial source reaches irq only if unmasked
// - three decoded channel addresses, last two parallel
module tipio_top #(
    parameter int unsigned TICK_PERIOD = tipio_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial ready flags
    input  wire logic [2:0]  rx_char_ready,
    input  wire logic [2:0]  tx_holding_ready,
    // serial handshakes
    input  wire logic [2:0]  hs_gate_in,
    input  wire logic [2:0]  hs_mon_in,
    output logic [2:0]       tx_enable,
    output logic [5:0]       hs_ctrl_out,
    // parallel channels
    output logic [7:0]       par_a_out,
    output logic [7:0]       par_b_out,
    input  wire logic [7:0]  par_a_in,
    input  wire logic [7:0]  par_b_in,
    // interrupt
    output logic             irq,
    output logic [6:0]       vi_lines
);
    import tipio_pkg::*;

    // ************************************************************
    // configuration and vector table
    // ************************************************************
    logic [NSRC-1:0] wire_q;
    logic            vi_en_q;
    logic [2:0]      gate_en_q;
    logic [3:0]      vec_sel_q;
    logic [7:0]      par_a_q;
    logic [7:0]      par_b_q;
    logic [NSRC-1:0] msk_q;
    logic [5:0]      hs_ctrl_q;
    logic            tick_latch;

    function automatic logic [7:0] vec_byte(input logic [3:0] sel);
        logic [7:0] v;
        v = VEC_DEFAULT;
        if (sel < 4'(NVEC - 1))
            v = {2'b11, sel[2:0], 3'b111};
        return v;
    endfunction

    // ************************************************************
    // tick and latch
    // ************************************************************
    logic tick;
    logic tick_clr;

    tipio_tick_gen #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    tipio_sticky u_tick_latch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (tick),
        .clr     (tick_clr),
        .q       (tick_latch)
    );

    // ************************************************************
    // interrupt sources
    // ************************************************************
    wire [NSRC-1:0] src_raw  = {tick_latch, tx_holding_ready, rx_char_ready};
    // serial sources pass channel A output as mask; tick is ungated
    wire [NSRC-1:0] ser_msk  = {1'b1, par_a_q[5:0]};
    wire [NSRC-1:0] src_live = src_raw & wire_q;
    wire [NSRC-1:0] src_act  = src_live & ser_msk;
    // parallel inputs never feed src_raw
    wire            irq_d    = |(src_act & msk_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq      <= 1'b0;
            vi_lines <= '0;
        end else begin
            irq      <= irq_d;
            vi_lines <= vi_en_q ? (src_act & msk_q) : '0;
        end
    end

    // handshake logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_enable   <= 3'b000;
            hs_ctrl_out <= 6'h00;
        end else begin
            tx_enable   <= ~gate_en_q | hs_gate_in;
            hs_ctrl_out <= hs_ctrl_q;
        end
    end

    // ************************************************************
    // axi write path
    // ************************************************************
    logic       aw_got_q;
    logic       w_got_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;

    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    wire   aw_hs   = s_axi_awvalid && s_axi_awready;
    wire   w_hs    = s_axi_wvalid && s_axi_wready;
    wire   have_aw = aw_got_q || aw_hs;
    wire   have_w  = w_got_q || w_hs;
    wire   do_wr   = have_aw && have_w;
    wire [7:0]  wa = aw_got_q ? aw_q : s_axi_awaddr;
    wire [31:0] wd = w_got_q ? wd_q : s_axi_wdata;
    wire [3:0]  wsb = w_got_q ? ws_q : s_axi_wstrb;
    wire   wr_ok   = (wa == OFS_PAR_A) || (wa == OFS_PAR_B) || (wa == OFS_CFG)
                  || (wa == OFS_IRQ_STAT) || (wa == OFS_IRQ_MASK)
                  || (wa == OFS_VEC_SEL) || (wa == OFS_HS_CTRL);
    wire   wr_b0   = do_wr && wsb[0];
    wire   wr_b1   = do_wr && wsb[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            aw_q         <= 8'h00;
            wd_q         <= 32'h0000_0000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (aw_hs) aw_q <= s_axi_awaddr;
            if (w_hs) begin
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            aw_got_q <= do_wr ? 1'b0 : have_aw;
            w_got_q  <= do_wr ? 1'b0 : have_w;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            par_a_q   <= RST_PAR_A;
            par_b_q   <= RST_PAR_B;
            wire_q    <= RST_WIRE;
            vi_en_q   <= 1'b0;
            gate_en_q <= 3'b000;
            vec_sel_q <= RST_VEC_SEL;
            msk_q     <= RST_IRQ_MASK;
            hs_ctrl_q <= 6'h00;
        end else begin
            if (wr_b0 && wa == OFS_PAR_A)    par_a_q <= wd[7:0];
            if (wr_b0 && wa == OFS_PAR_B)    par_b_q <= wd[7:0];
            if (wr_b0 && wa == OFS_CFG)      wire_q  <= wd[CFG_WIRE_LSB +: NSRC];
            if (wr_b1 && wa == OFS_CFG) begin
                vi_en_q   <= wd[CFG_VI_BIT];
                gate_en_q <= wd[CFG_GATE_LSB +: 3];
            end
            if (wr_b0 && wa == OFS_VEC_SEL)  vec_sel_q <= wd[3:0];
            if (wr_b0 && wa == OFS_IRQ_MASK) msk_q     <= wd[NSRC-1:0];
            if (wr_b0 && wa == OFS_HS_CTRL)  hs_ctrl_q <= wd[5:0];
        end
    end

    // status w1c on the tick latch: clear via channel B read or write-one
    wire w1c_tick = wr_b0 && (wa == OFS_IRQ_STAT) && wd[SRC_TICK];

    // ************************************************************
    // axi read path
    // ************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    wire   ar_hs  = s_axi_arvalid && s_axi_arready;
    wire [7:0] ra = s_axi_araddr;
    wire   rd_b   = ar_hs && (ra == OFS_PAR_B);
    assign tick_clr = rd_b || w1c_tick;

    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        unique case (ra)
            OFS_SER_STAT: rd_val = {26'h0, tx_holding_ready, rx_char_ready};
            OFS_PAR_A:    rd_val = {24'h0, par_a_in};
            OFS_PAR_B:    rd_val = {24'h0, par_b_in};
            OFS_CFG:      rd_val = {20'h0, gate_en_q, vi_en_q, 1'b0, wire_q};
            OFS_IRQ_STAT: rd_val = {25'h0, src_live};
            OFS_IRQ_MASK: rd_val = {25'h0, msk_q};
            OFS_VEC_SEL:  rd_val = {28'h0, vec_sel_q};
            OFS_HS_CTRL:  rd_val = {26'h0, hs_ctrl_q};
            OFS_HS_STAT:  rd_val = {29'h0, hs_mon_in};
            OFS_IACK:     rd_val = {24'h0, vec_byte(vec_sel_q)};
            default:      rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // parallel outputs driven from latched registers
    assign par_a_out = par_a_q;
    assign par_b_out = par_b_q;

    // ************************************************************
    // checks
    // ************************************************************
    property p_clr_on_b_read;
        @(posedge aclk) disable iff (!aresetn)
        (rd_b && !tick) |=> !tick_latch;
    endproperty
    a_clr_on_b_read: assert property (p_clr_on_b_read)
        else $error("channel B read did not clear tick latch");

    property p_tick_irq;
        @(posedge aclk) disable iff (!aresetn)
        (tick_latch && wire_q[SRC_TICK] && msk_q[SRC_TICK]) |=> irq;
    endproperty
    a_tick_irq: assert property (p_tick_irq)
        else $error("tick latch set but no irq");

    property p_irq_or;
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> (irq == $past(|(src_raw & wire_q & ser_msk & msk_q)));
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("irq not OR of enabled sources");

    property p_masked_serial;
        @(posedge aclk) disable iff (!aresetn)
        (par_a_q[5:0] == 6'h00 && !tick_latch) |=> !irq;
    endproperty
    a_masked_serial: assert property (p_masked_serial)
        else $error("masked serial source raised irq");

    property p_par_hold;
        @(posedge aclk) disable iff (!aresetn)
        !(wr_b0 && wa == OFS_PAR_B) |=> $stable(par_b_out);
    endproperty
    a_par_hold: assert property (p_par_hold)
        else $error("channel B output changed without write");

    property p_live_read;
        @(posedge aclk) disable iff (!aresetn)
        rd_b |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(par_b_in));
    endproperty
    a_live_read: assert property (p_live_read)
        else $error("channel B read not live pins");

    property p_vec;
        @(posedge aclk) disable iff (!aresetn)
        (ar_hs && ra == OFS_IACK) |=> (s_axi_rdata[7:0] == vec_byte($past(vec_sel_q)));
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector byte wrong");

    property p_vi_off;
        @(posedge aclk) disable iff (!aresetn)
        !vi_en_q |=> (vi_lines == 7'h00);
    endproperty
    a_vi_off: assert property (p_vi_off)
        else $error("vi lines active while disabled");

    property p_gate;
        @(posedge aclk) disable iff (!aresetn)
        (gate_en_q[0] && !hs_gate_in[0]) |=> !tx_enable[0];
    endproperty
    a_gate: assert property (p_gate)
        else $error("transmitter not gated off");

    property p_w1c_clr;
        @(posedge aclk) disable iff (!aresetn)
        (w1c_tick && !tick) |=> !tick_latch;
    endproperty
    a_w1c_clr: assert property (p_w1c_clr)
        else $error("write-one did not clear tick latch");
endmodule
`default_nettype wire

/* File: test/tipio_host.sv */
// tipio_host: processor-side model, drives the block over AXI4-Lite
// assumes: one clock, caller serialises wr and rd calls
`timescale 1ns/1ps
`default_nettype none
module tipio_host (
    // clock
    input  wire logic        aclk,
    // write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // ************************************************************
    // bus cycles
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: test/tipio_top_tb.sv */
// tipio_top_tb: register-level tests of tipio_top
// assumes: tipio_host model, short tick period
`timescale 1ns/1ps
`default_nettype none
module tipio_top_tb;
    import tipio_pkg::*;
    localparam int TP    = 50;
    localparam int LIMIT = 3000;
    logic aclk, aresetn;
    logic [7:0]  awaddr, araddr, par_a_out, par_b_out, pai, pbi;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [2:0]  rxr, txr, gin, mon, tx_enable;
    logic [5:0]  hs_ctrl_out;
    logic [6:0]  vi_lines;
    int          cyc = 0;
    int          t1;
    int          error_cnt = 0;
    int          samples_checked = 0;

    tipio_top #(.TICK_PERIOD(TP)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_char_ready(rxr), .tx_holding_ready(txr), .hs_gate_in(gin),
        .hs_mon_in(mon), .tx_enable(tx_enable), .hs_ctrl_out(hs_ctrl_out),
        .par_a_out(par_a_out), .par_b_out(par_b_out), .par_a_in(pai),
        .par_b_in(pbi), .irq(irq), .vi_lines(vi_lines));

    tipio_host h (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // ************************************************************
    // clock, timeout, helpers
    // ************************************************************
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        h.wr(a, v, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        h.rd(a, d, r);
        chk(d, e);
    endtask

    task automatic wait_irq;
        int k = 0;
        // let a level left over from a just-cleared latch drop first
        while (irq === 1'b1 && k < TP) begin
            @(posedge aclk);
            k++;
        end
        while (irq !== 1'b1 && k < 4 * TP) begin
            @(posedge aclk);
            k++;
        end
    endtask

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        aresetn = 1'b0;
        {rxr, txr, gin, mon, pai, pbi} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({16'h0, par_b_out, par_a_out}, 32'h0000);
        wr(OFS_PAR_A, 32'hA5);
        wr(OFS_PAR_B, 32'h3C);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        pai <= 8'h5A;
        pbi <= 8'hC3;
        repeat (2) @(posedge aclk);
        rdc(OFS_PAR_A, 32'h5A);
        rdc(OFS_PAR_B, 32'hC3);
        chk({16'h0, par_b_out, par_a_out}, 32'h3CA5);
        chk({31'h0, irq}, 32'h0);
        h.rd(8'h08, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        h.wr(8'h08, 32'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("parallel test done");

        // serial sources gated by channel A output
        wr(OFS_PAR_A, 32'h0);
        wr(OFS_CFG, 32'h3F);
        wr(OFS_IRQ_MASK, 32'h3F);
        for (int i = 0; i < 6; i++) begin
            {txr, rxr} <= 6'(1 << i);
            repeat (3) @(posedge aclk);
            chk({31'h0, irq}, 32'h0);
            rdc(OFS_SER_STAT, 32'(1 << i));
            wr(OFS_PAR_A, 32'(1 << i));
            repeat (2) @(posedge aclk);
            chk({31'h0, irq}, 32'h1);
            wr(OFS_PAR_A, 32'h0);
        end
        {txr, rxr} <= 6'h00;
        $display("serial interrupt test done");

        gin <= 3'b010;
        mon <= 3'b110;
        wr(OFS_CFG, 32'hE00);
        wr(OFS_HS_CTRL, 32'h2D);
        repeat (2) @(posedge aclk);
        chk({29'h0, tx_enable}, 32'h2);
        chk({26'h0, hs_ctrl_out}, 32'h2D);
        rdc(OFS_HS_STAT, 32'h6);
        $display("handshake test done");

        // tick latch: clear right after a tick so the next rise is clean
        wr(OFS_CFG, 32'h140);
        wr(OFS_IRQ_MASK, 32'h40);
        rdc(OFS_PAR_B, 32'hC3);
        wait_irq();
        rdc(OFS_PAR_B, 32'hC3);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wait_irq();
        t1 = cyc;
        chk({25'h0, vi_lines}, 32'h40);
        rdc(OFS_IRQ_STAT, 32'h40);
        repeat (TP) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rdc(OFS_PAR_B, 32'hC3);
        wait_irq();
        chk((cyc - t1) % TP, 32'h0);
        wr(OFS_IRQ_STAT, 32'h40);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_IRQ_STAT, 32'h0);
        for (int s = 0; s < 9; s++) begin
            wr(OFS_VEC_SEL, 32'(s));
            rdc(OFS_IACK, (s < 8) ? {24'h0, 2'b11, 3'(s), 3'b111} : 32'hFF);
        end
        wr(OFS_CFG, 32'h40);
        repeat (2) @(posedge aclk);
        chk({25'h0, vi_lines}, 32'h0);
        $display("tick and vector test done");
        test_done();
    end
endmodule
`default_nettype wire
